/* File: src/hbe_pkg.sv */
/*
 * Constants for the half-bridge enable register bank: the serial frame
 * layout, the address decode fields, the reset values and the frame state
 * type.
 * Assumes one 25 MHz system clock. The serial pins are treated as
 * synchronous to that clock and are simply edge-detected.
 */
package hbe_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 8;
    localparam logic [4:0] BITCNT_FRAME = 5'h10;
    localparam logic [4:0] BITCNT_ADDR_LAST = 5'h07;
    localparam logic [4:0] BITCNT_MAX = 5'h1F;
    localparam int OP_BIT = 7;
    localparam int CTRL_BIT = 0;
    localparam int FIELD_HI = 6;
    localparam int FIELD_LO = 2;

    ////////////////////////////////////////////////////////////////////////////
    // address fields in bits 6..2
    localparam logic [4:0] FLD_GRP_A = 5'h00;
    localparam logic [4:0] FLD_GRP_B = 5'h10;
    localparam logic [4:0] FLD_CONFIG = 5'h1F;
    localparam logic [4:0] FLD_STATUS = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and status fields
    localparam logic [7:0] GRP_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST = 8'h01;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;
    localparam int STAT_FRAME_ERR_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // frame tracking states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA
    } hbe_state_t;

endpackage

/* File: src/hbe_xguard.sv */
/*
 * Cross-current guard for one half-bridge: registers the two switch drives
 * from the stored enable bits.
 * Assumes the enable bits come straight from the host-written register.
 */
`timescale 1ns/1ps
module hbe_xguard import hbe_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // stored enables
    input wire logic upperEnable,
    input wire logic lowerEnable,
    // switch drives
    output logic upperSwitchOn,
    output logic lowerSwitchOn
);

    logic upper_nxt;
    logic lower_nxt;
    logic upper_r;
    logic lower_r;
    logic bothSet;

    ////////////////////////////////////////////////////////////////////////////
    // both set means a shoot-through path, so the bridge is forced off
    always_comb begin
        bothSet = upperEnable && lowerEnable;
        upper_nxt = upperEnable && !bothSet;
        lower_nxt = lowerEnable && !bothSet;
    end

    // drives start off so nothing conducts before the host asks
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            upper_r <= 1'b0;
            lower_r <= 1'b0;
        end else begin
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
        end
    end

    assign upperSwitchOn = upper_r;
    assign lowerSwitchOn = lower_r;

    property p_noShootThrough;
        @(posedge sys_clk) disable iff (!arst_n) 1'b1 |-> !(upperSwitchOn && lowerSwitchOn);
    endproperty
    a_noShootThrough: assert property (p_noShootThrough) else $error("both switches of a bridge on");

    property p_singleEnableDrives;
        @(posedge sys_clk) disable iff (!arst_n)
            (upperEnable != lowerEnable) |=> (upperSwitchOn == $past(upperEnable)) && (lowerSwitchOn == $past(lowerEnable));
    endproperty
    a_singleEnableDrives: assert property (p_singleEnableDrives) else $error("single enable not driven");

endmodule // hbe_xguard

/* File: src/hbe_regs.sv */
/*
 * Serial-programmed enable register bank for eight half-bridges: 16-bit
 * frame slave, group A/B enable registers, configuration register, frame
 * status register and the per-bridge drive guards.
 * Assumes the host drives chip select low for a whole frame, sends bits
 * least significant first, changes data while the serial clock is low and
 * keeps the serial clock well below half the system clock.
 */
`timescale 1ns/1ps
module hbe_regs import hbe_pkg::*; #(
    parameter int BRIDGES = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // serial link
    input wire logic spiCsN,
    input wire logic spiSck,
    input wire logic spiMosi,
    output logic spiMisoOut,
    output logic spiMisoOe,
    // switch drives, bridge 1 in bit 0
    output logic [BRIDGES-1:0] upperSwitchOn,
    output logic [BRIDGES-1:0] lowerSwitchOn,
    // configuration byte
    output logic [7:0] configCtrl
);

    hbe_state_t state_r, state_nxt;
    logic [4:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] rxSh_r, rxSh_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] txSh_r, txSh_nxt;
    logic misoBit_r, misoBit_nxt;
    logic sckPrev_r;
    logic csPrev_r;
    logic [7:0] grpA_r, grpA_nxt;
    logic [7:0] grpB_r, grpB_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] stat_r, stat_nxt;
    logic sckRise;
    logic sckFall;
    logic frameStart;
    logic frameEnd;
    logic commit;
    logic frameErr;
    logic [7:0] addrNow;

    ////////////////////////////////////////////////////////////////////////////
    // read multiplexer; unmapped addresses answer zero
    function automatic logic [7:0] readReg(input logic [7:0] a, input logic [7:0] ga, input logic [7:0] gb,
                                           input logic [7:0] cf, input logic [7:0] st);
        logic [4:0] fld;
        fld = a[FIELD_HI:FIELD_LO];
        if (a[CTRL_BIT]) begin
            case (fld)
                FLD_GRP_A: readReg = ga;
                FLD_GRP_B: readReg = gb;
                FLD_CONFIG: readReg = cf;
                default: readReg = READ_NONE;
            endcase
        end else begin
            readReg = (fld == FLD_STATUS) ? st : READ_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // edge detection; pins are taken as synchronous, so no synchroniser
    assign sckRise = !spiCsN && spiSck && !sckPrev_r;
    assign sckFall = !spiCsN && !spiSck && sckPrev_r;
    assign frameStart = !spiCsN && csPrev_r;
    assign frameEnd = spiCsN && !csPrev_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sckPrev_r <= 1'b0;
            csPrev_r <= 1'b1;
        end else begin
            sckPrev_r <= spiSck;
            csPrev_r <= spiCsN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame shifter: address byte first, then data byte, lsb first
    always_comb begin
        state_nxt = state_r;
        bitCnt_nxt = bitCnt_r;
        rxSh_nxt = rxSh_r;
        addr_nxt = addr_r;
        txSh_nxt = txSh_r;
        misoBit_nxt = misoBit_r;
        commit = 1'b0;
        frameErr = 1'b0;
        addrNow = {spiMosi, rxSh_r[7:1]};
        case (state_r)
            ST_IDLE: begin
                if (frameStart) begin
                    // status goes out while the address comes in
                    state_nxt = ST_ADDR;
                    bitCnt_nxt = 5'h00;
                    misoBit_nxt = stat_r[0];
                    txSh_nxt = {1'b0, stat_r[7:1]};
                end
            end
            ST_ADDR, ST_DATA: begin
                if (frameEnd) begin
                    state_nxt = ST_IDLE;
                    // a short or long frame is dropped whole
                    commit = (state_r == ST_DATA) && (bitCnt_r == BITCNT_FRAME);
                    frameErr = !commit;
                end else if (sckRise) begin
                    rxSh_nxt = addrNow;
                    if (bitCnt_r != BITCNT_MAX) begin
                        bitCnt_nxt = bitCnt_r + 5'h01;
                    end
                    if (state_r == ST_ADDR && bitCnt_r == BITCNT_ADDR_LAST) begin
                        // data byte returns the register as it was before this frame
                        state_nxt = ST_DATA;
                        addr_nxt = addrNow;
                        txSh_nxt = readReg(addrNow, grpA_r, grpB_r, cfg_r, stat_r);
                    end
                end else if (sckFall) begin
                    misoBit_nxt = txSh_r[0];
                    txSh_nxt = {1'b0, txSh_r[7:1]};
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            bitCnt_r <= 5'h00;
            rxSh_r <= 8'h00;
            addr_r <= 8'h00;
            txSh_r <= 8'h00;
            misoBit_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
            rxSh_r <= rxSh_nxt;
            addr_r <= addr_nxt;
            txSh_r <= txSh_nxt;
            misoBit_r <= misoBit_nxt;
        end
    end

    // pin floats outside a frame so several devices can share it
    assign spiMisoOut = misoBit_r;
    assign spiMisoOe = !spiCsN;

    ////////////////////////////////////////////////////////////////////////////
    // register file: only a complete write frame may change a control bit
    always_comb begin
        grpA_nxt = grpA_r;
        grpB_nxt = grpB_r;
        cfg_nxt = cfg_r;
        stat_nxt = stat_r;
        if (commit && addr_r[OP_BIT]) begin
            if (addr_r[CTRL_BIT]) begin
                case (addr_r[FIELD_HI:FIELD_LO])
                    FLD_GRP_A: grpA_nxt = rxSh_r;
                    FLD_GRP_B: grpB_nxt = rxSh_r;
                    FLD_CONFIG: cfg_nxt = rxSh_r;
                    default: ;
                endcase
            end else if (addr_r[FIELD_HI:FIELD_LO] == FLD_STATUS) begin
                stat_nxt = STATUS_RST;
            end
        end
        // a new error in the clearing cycle is kept
        if (frameErr) begin
            stat_nxt[STAT_FRAME_ERR_BIT] = 1'b1;
        end
    end

    // one reset input covers both power-on and device reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            grpA_r <= GRP_RST;
            grpB_r <= GRP_RST;
            cfg_r <= CONFIG_RST;
            stat_r <= STATUS_RST;
        end else begin
            grpA_r <= grpA_nxt;
            grpB_r <= grpB_nxt;
            cfg_r <= cfg_nxt;
            stat_r <= stat_nxt;
        end
    end

    assign configCtrl = cfg_r;

    ////////////////////////////////////////////////////////////////////////////
    // one guard per bridge; even bit lower switch, odd bit upper switch
    logic [2*BRIDGES-1:0] enableBits;
    assign enableBits = {grpB_r, grpA_r};

    for (genvar i = 0; i < BRIDGES; i++) begin : g_bridge
        hbe_xguard u_guard (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .upperEnable(enableBits[2*i+1]),
            .lowerEnable(enableBits[2*i]),
            .upperSwitchOn(upperSwitchOn[i]),
            .lowerSwitchOn(lowerSwitchOn[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_resetGroups;
        @(posedge sys_clk) $rose(arst_n) |-> (grpA_r == GRP_RST) && (grpB_r == GRP_RST);
    endproperty
    a_resetGroups: assert property (p_resetGroups) else $error("enable groups not zero after reset");

    property p_resetConfig;
        @(posedge sys_clk) $rose(arst_n) |-> (cfg_r == CONFIG_RST);
    endproperty
    a_resetConfig: assert property (p_resetConfig) else $error("config not 0x01 after reset");

    property p_noSpontaneousChange;
        @(posedge sys_clk) disable iff (!arst_n) !commit |=> $stable({grpA_r, grpB_r, cfg_r});
    endproperty
    a_noSpontaneousChange: assert property (p_noSpontaneousChange) else $error("control bits changed without write");

    property p_readLeaves;
        @(posedge sys_clk) disable iff (!arst_n) (commit && !addr_r[OP_BIT]) |=> $stable({grpA_r, grpB_r, cfg_r});
    endproperty
    a_readLeaves: assert property (p_readLeaves) else $error("read changed a register");

    property p_writeGroupA;
        @(posedge sys_clk) disable iff (!arst_n)
            (commit && addr_r[OP_BIT] && addr_r[CTRL_BIT] && addr_r[FIELD_HI:FIELD_LO] == FLD_GRP_A)
            |=> (grpA_r == $past(rxSh_r)) ##2 (lowerSwitchOn[0] == (grpA_r[0] && !grpA_r[1]));
    endproperty
    a_writeGroupA: assert property (p_writeGroupA) else $error("group A write or drive wrong");

    property p_writeGroupB;
        @(posedge sys_clk) disable iff (!arst_n)
            (commit && addr_r[OP_BIT] && addr_r[CTRL_BIT] && addr_r[FIELD_HI:FIELD_LO] == FLD_GRP_B)
            |=> (grpB_r == $past(rxSh_r)) && $stable(grpA_r);
    endproperty
    a_writeGroupB: assert property (p_writeGroupB) else $error("group B write wrong");

    property p_badFrameDropped;
        @(posedge sys_clk) disable iff (!arst_n)
            (frameEnd && state_r != ST_IDLE && !(state_r == ST_DATA && bitCnt_r == BITCNT_FRAME))
            |=> stat_r[STAT_FRAME_ERR_BIT] && $stable({grpA_r, grpB_r, cfg_r});
    endproperty
    a_badFrameDropped: assert property (p_badFrameDropped) else $error("bad frame not dropped");

    property p_statusClear;
        @(posedge sys_clk) disable iff (!arst_n)
            (commit && addr_r[OP_BIT] && !addr_r[CTRL_BIT] && addr_r[FIELD_HI:FIELD_LO] == FLD_STATUS)
            |=> (stat_r == STATUS_RST);
    endproperty
    a_statusClear: assert property (p_statusClear) else $error("status not cleared");

endmodule // hbe_regs

/* File: verif/hbe_host_model.sv */
/*
 * Host master model for the enable register bank: drives frames of up to 16 bits,
 * lsb first, sampling on the serial clock rise and changing data while low.
 * Assumes one system clock; all pins change just after its rising edge.
 */
`timescale 1ns/1ps
module hbe_host_model (
    // clock
    input wire logic sys_clk,
    // serial link
    output logic spiCsN,
    output logic spiSck,
    output logic spiMosi,
    input wire logic spiMisoOut,
    input wire logic spiMisoOe
);
    logic idleTog = 1'b0;
    logic misoLine;

    ////////////////////////////////////////////////////////////////////////////
    // released reply line toggles each cycle so a stale bit can never match
    initial begin
        spiCsN = 1'b1;
        spiSck = 1'b0;
        spiMosi = 1'b0;
    end
    always @(posedge sys_clk) begin
        idleTog <= ~idleTog;
    end
    assign misoLine = spiMisoOe ? spiMisoOut : idleTog;

    ////////////////////////////////////////////////////////////////////////////
    // one frame; serial clock stands low outside frames, low phase of three
    // cycles gives the reply bit time to settle before it is sampled
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge sys_clk);
        spiCsN <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spiMosi <= tx[i];
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            rx[i] = misoLine;
            @(posedge sys_clk);
            spiSck <= 1'b1;
            repeat (2) @(posedge sys_clk);
            spiSck <= 1'b0;
        end
        repeat (2) @(posedge sys_clk);
        spiCsN <= 1'b1;
        spiMosi <= ~spiMosi; // data line inverted after the frame
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

endmodule // hbe_host_model

/* File: verif/hbe_regs_tb.sv */
/*
 * Self-checking bench for the enable register bank: frames through the host
 * model, expected values from the bit layout, a mid-run reset at the end.
 * Assumes the design outputs settle two cycles after a frame ends.
 */
`timescale 1ns/1ps
module hbe_regs_tb import hbe_pkg::*; ;
    logic sys_clk;
    logic arst_n;
    logic spiCsN;
    logic spiSck;
    logic spiMosi;
    logic spiMisoOut;
    logic spiMisoOe;
    logic [7:0] upperSwitchOn;
    logic [7:0] lowerSwitchOn;
    logic [7:0] configCtrl;
    logic [15:0] rx;
    logic [15:0] en;
    logic [7:0] d;
    int nErrors = 0;
    int compares = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////////
    // clock, design and host
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    hbe_regs #(.BRIDGES(8)) DUT (.sys_clk(sys_clk), .arst_n(arst_n), .spiCsN(spiCsN), .spiSck(spiSck),
        .spiMosi(spiMosi), .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe), .upperSwitchOn(upperSwitchOn),
        .lowerSwitchOn(lowerSwitchOn), .configCtrl(configCtrl));
    hbe_host_model host (.sys_clk(sys_clk), .spiCsN(spiCsN), .spiSck(spiSck), .spiMosi(spiMosi),
        .spiMisoOut(spiMisoOut), .spiMisoOe(spiMisoOe));

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic results();
        if (nErrors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] adr(input logic wrOp, input logic [4:0] fld, input logic tok, input logic ctl);
        return {wrOp, fld, tok, ctl};
    endfunction
    // bridge i uses bits 2i (lower) and 2i+1 (upper); both set means both off
    function automatic logic [7:0] drv(input logic [15:0] e, input logic up);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = up ? (e[2*i+1] & ~e[2*i]) : (e[2*i] & ~e[2*i+1]);
        end
        return r;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        host.xfer({v, a}, 16, rx);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        host.xfer({8'h00, a}, 16, rx);
        v = rx[15:8];
    endtask
    // drives first, then both stored bytes read back as written
    task automatic chkGrp(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] v;
        chk8("upper drive", drv({b, a}, 1'b1), upperSwitchOn);
        chk8("lower drive", drv({b, a}, 1'b0), lowerSwitchOn);
        rd(adr(1'b0, FLD_GRP_A, 1'b0, 1'b1), v);
        chk8("group a", a, v);
        rd(adr(1'b0, FLD_GRP_B, 1'b1, 1'b1), v);
        chk8("group b", b, v);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard; a full run takes about 8000 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 30000) begin
            nErrors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        arst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk8("config", 8'h01, configCtrl);
        chk8("reply enable idle", 8'h00, {7'h00, spiMisoOe});
        chkGrp(8'h00, 8'h00);
        // walk one enable bit across both groups, token bit toggled
        for (int b = 0; b < 16; b++) begin
            en = 16'h0001 << b;
            wr(adr(1'b1, FLD_GRP_A, b[0], 1'b1), en[7:0]);
            wr(adr(1'b1, FLD_GRP_B, ~b[0], 1'b1), en[15:8]);
            chkGrp(en[7:0], en[15:8]);
        end
        // both enables of a bridge: drive off, stored bits kept
        wr(adr(1'b1, FLD_GRP_A, 1'b0, 1'b1), 8'hFF);
        wr(adr(1'b1, FLD_GRP_B, 1'b0, 1'b1), 8'h36);
        chkGrp(8'hFF, 8'h36);
        // a read carrying a non-zero data byte leaves the register alone
        host.xfer({8'hA5, adr(1'b0, FLD_GRP_A, 1'b0, 1'b1)}, 16, rx);
        chkGrp(8'hFF, 8'h36);
        wr(adr(1'b1, FLD_GRP_A, 1'b0, 1'b1), 8'h00);
        chk8("old value", 8'hFF, rx[15:8]);
        // unmapped place takes no write and reads zero
        wr(adr(1'b1, 5'h01, 1'b0, 1'b1), 8'hFF);
        rd(adr(1'b0, 5'h01, 1'b0, 1'b1), d);
        chk8("unmapped", 8'h00, d);
        chkGrp(8'h00, 8'h36);
        wr(adr(1'b1, FLD_CONFIG, 1'b1, 1'b1), 8'h5A);
        chk8("config", 8'h5A, configCtrl);
        // the configuration register also answers on the serial link
        rd(adr(1'b0, FLD_CONFIG, 1'b0, 1'b1), d);
        chk8("config read", 8'h5A, d);
        // short frame refused and flagged, flag cleared by op bit high
        host.xfer({8'h00, adr(1'b1, FLD_GRP_B, 1'b0, 1'b1)}, 15, rx);
        rd(adr(1'b0, FLD_STATUS, 1'b0, 1'b0), d);
        chk8("status", 8'h80, d);
        chk8("status head", 8'h80, rx[7:0]);
        rd(adr(1'b0, FLD_STATUS, 1'b0, 1'b0), d);
        chk8("status kept", 8'h80, d);
        wr(adr(1'b1, FLD_STATUS, 1'b0, 1'b0), 8'h00);
        rd(adr(1'b0, FLD_STATUS, 1'b0, 1'b0), d);
        chk8("status cleared", 8'h00, d);
        // nothing changes by itself while idle
        repeat (300) @(posedge sys_clk);
        @(negedge sys_clk);
        chk8("config", 8'h5A, configCtrl);
        chkGrp(8'h00, 8'h36);
        // second reset in mid-run restores the defaults
        @(posedge sys_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk8("config", 8'h01, configCtrl);
        chkGrp(8'h00, 8'h00);
        rd(adr(1'b0, FLD_CONFIG, 1'b1, 1'b1), d);
        chk8("config read", 8'h01, d);
        results();
    end

endmodule // hbe_regs_tb
